// ### verilog/fawm_monitor.sv
// Fault status, mask, alarm action and watchdog of a quad output converter
//
// Behaviour
// R1: Reference stays off after reset until software sets its enable bit.
// R2: Any reset returns registers to defaults and channel outputs disabled.
// R3: Voltage output defaults to 30k to ground; select bit makes it high-Z.
// R4: Open current output persisting over 500 us raises alarm.
// R5: Compliance loss over 500 us alarms, optionally only when rail saturated.
// R6: Over-temperature, watchdog, CRC, short over 500 us, rail maximum also alarm.
// R7: Alarm tracks faults; CRC, watchdog and open alarm with rail converter latch until cleared.
// R8: Open action 10 disables channel and makes open alarm non-latched.
// R9: Supply-ok per channel needs enabled arms inside limits; disabled arms ignored.
// R10: Status bits sticky until write-one-clear or reset; reset takes 8 us.
// R11: Cleared status bit sets again while the fault remains.
// R12: Mask mirrors status order; masked bits never drive the alarm.
// R13: Action priority: over-temperature, output fault, then CRC or watchdog.
// R14: Action 01 loads the fault code and keeps it after fault clears.
// R15: Fault code is applied as a step, bypassing slew stepping.
// R16: Watchdog runs only when enabled; 2-bit field selects timeout.
// R17: Host writes refresh address before every timeout expires.
// R18: Missed refresh pulls alarm low and sets watchdog timeout flag.
// R19: Timeout flag cleared by reset or by disabling the watchdog.
// R20: Host reads every device status on a shared alarm line.
// R21: Clamp-learned flag set once load learning fills the clamp level.
// R22: Alarm pin pulled low whenever an unmasked fault is present.
`include "fawm_regs.svh"
`default_nettype none
module fawm_monitor
  import fawm_pkg::*;
#(
  parameter int unsigned FLT_CYC = `FAWM_FLT_US * `FAWM_CLK_MHZ,
  parameter int unsigned WD_CYC0 = `FAWM_WD_US0 * `FAWM_CLK_MHZ,
  parameter int unsigned WD_CYC1 = `FAWM_WD_US1 * `FAWM_CLK_MHZ,
  parameter int unsigned WD_CYC2 = `FAWM_WD_US2 * `FAWM_CLK_MHZ,
  parameter int unsigned WD_CYC3 = `FAWM_WD_US3 * `FAWM_CLK_MHZ
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Register access
  input  wire fawm_req_t  req,
  output logic [15:0]     rdata,
  // Fault sensing
  input  wire fawm_flt_t  flt,
  // Open-drain alarm pin
  output logic            alarm_out,
  output logic            alarm_oe_n,
  // Analog control
  output logic            ref_en,
  output logic            vout_hiz,
  output logic [3:0]      chan_off,
  output logic            code_apply,
  output logic            code_step,
  output logic [5:0]      code_value,
  output logic [1:0]      act_applied
);
  // ========================================================
  // Reset sequencer
  localparam logic [7:0] SRST_CYC = 8'(`FAWM_SRST_CYC);
  fawm_seq_t  seq_r, seq_nxt;
  logic [7:0] sc_r, sc_nxt;
  logic       run;
  logic       wr_ok;
  assign run   = (seq_r == FAWM_RUN);
  assign wr_ok = req.wr && run;

  always_comb begin
    seq_nxt = seq_r;
    sc_nxt  = sc_r;
    case (seq_r)
      FAWM_RUN: begin
        if (wr_ok && req.addr == `FAWM_A_SWRST) begin
          seq_nxt = FAWM_CLR;
          sc_nxt  = 8'h00;
        end
      end
      FAWM_CLR: begin
        // Held long enough for the status clear to settle
        sc_nxt = sc_r + 8'h01;
        if (sc_r == SRST_CYC - 8'h01) begin
          seq_nxt = FAWM_RUN; // R10
        end
      end
      default: seq_nxt = FAWM_CLR;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seq_r <= FAWM_CLR;
      sc_r  <= 8'h00;
    end else begin
      seq_r <= seq_nxt;
      sc_r  <= sc_nxt;
    end
  end

  // ========================================================
  // Control registers
  logic [1:0] ref_r, ref_nxt;
  logic [3:0] wdc_r, wdc_nxt;
  logic [6:0] msk_r, msk_nxt;
  logic [7:0] act_r, act_nxt;
  logic [5:0] code_r, code_nxt;

  always_comb begin
    ref_nxt  = ref_r;
    wdc_nxt  = wdc_r;
    msk_nxt  = msk_r;
    act_nxt  = act_r;
    code_nxt = code_r;
    if (!run) begin
      ref_nxt  = `FAWM_RST_REF; // R1
      wdc_nxt  = `FAWM_RST_WDC;
      msk_nxt  = `FAWM_RST_MSK;
      act_nxt  = `FAWM_RST_ACT;
      code_nxt = `FAWM_RST_CODE; // R2
    end else if (req.wr) begin
      case (req.addr)
        `FAWM_A_REF:  ref_nxt  = req.wdata[1:0]; // R1
        `FAWM_A_WDC:  wdc_nxt  = req.wdata[3:0];
        `FAWM_A_MSK:  msk_nxt  = req.wdata[6:0];
        `FAWM_A_ACT:  act_nxt  = req.wdata[7:0];
        `FAWM_A_CODE: code_nxt = req.wdata[5:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ref_r  <= `FAWM_RST_REF;
      wdc_r  <= `FAWM_RST_WDC;
      msk_r  <= `FAWM_RST_MSK;
      act_r  <= `FAWM_RST_ACT;
      code_r <= `FAWM_RST_CODE;
    end else begin
      ref_r  <= ref_nxt;
      wdc_r  <= wdc_nxt;
      msk_r  <= msk_nxt;
      act_r  <= act_nxt;
      code_r <= code_nxt;
    end
  end

  logic [1:0] ot_act, out_act, cw_act, ioc_act;
  assign ot_act  = act_r[`FAWM_ACT_OT +: 2];
  assign out_act = act_r[`FAWM_ACT_OUT +: 2];
  assign cw_act  = act_r[`FAWM_ACT_CW +: 2];
  assign ioc_act = act_r[`FAWM_ACT_IOC +: 2];

  // ========================================================
  // Persistence filters: open, compliance and short per channel
  localparam logic [15:0] FLT_LIM = 16'(FLT_CYC);
  logic [11:0] raw, qual;
  logic [15:0] pc_r [12];
  logic [15:0] pc_nxt [12];
  logic [3:0]  comp_raw;
  // Saturation option suppresses compliance alarms on channels whose sat bit is low
  assign comp_raw = flt.comp & (flt.sat | {4{~wdc_r[`FAWM_WD_SAT]}}); // R5
  assign raw      = {flt.shrt, comp_raw, flt.open};

  always_comb begin
    for (int i = 0; i < 12; i++) begin
      if (!raw[i] || !run) begin
        pc_nxt[i] = 16'h0000;
      end else if (pc_r[i] == FLT_LIM) begin
        pc_nxt[i] = pc_r[i];
      end else begin
        pc_nxt[i] = pc_r[i] + 16'h0001; // R4
      end
      qual[i] = (pc_r[i] == FLT_LIM);
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 12; i++) begin
      if (rst) begin
        pc_r[i] <= 16'h0000;
      end else begin
        pc_r[i] <= pc_nxt[i];
      end
    end
  end

  logic q_open, q_comp, q_short;
  assign q_open  = |qual[3:0];
  assign q_comp  = |qual[7:4];
  assign q_short = |qual[11:8];

  // ========================================================
  // Watchdog
  logic [23:0] wd_r, wd_nxt, wd_lim;
  logic        wd_en, wd_to, wd_kick;
  assign wd_en   = wdc_r[`FAWM_WD_EN];
  assign wd_kick = wr_ok && req.addr == `FAWM_A_WDR;
  assign wd_to   = wd_en && wd_r == wd_lim;

  always_comb begin
    case (wdc_r[`FAWM_WD_PER +: 2])
      2'h0:    wd_lim = 24'(WD_CYC0);
      2'h1:    wd_lim = 24'(WD_CYC1);
      2'h2:    wd_lim = 24'(WD_CYC2);
      default: wd_lim = 24'(WD_CYC3); // R16
    endcase
    if (!wd_en || wd_kick) begin
      wd_nxt = 24'h000000; // R16
    end else if (wd_to) begin
      wd_nxt = wd_r;
    end else begin
      wd_nxt = wd_r + 24'h000001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wd_r <= 24'h000000;
    end else begin
      wd_r <= wd_nxt;
    end
  end

  // ========================================================
  // Sticky status and supply-ok
  logic [7:0] sts_r, sts_nxt, sts_set, w1c;
  logic [3:0] pg_r, pg_nxt;
  assign sts_set = {flt.clamp_done, |flt.rail, q_short, flt.crc_err,
                    wd_to, flt.ot, q_comp, q_open}; // R6 R21
  assign w1c = (wr_ok && req.addr == `FAWM_A_STS) ? req.wdata[7:0] : 8'h00;

  always_comb begin
    // Set wins over a simultaneous clear
    sts_nxt = (sts_r & ~w1c) | sts_set; // R10 R11
    if (!wd_en) begin
      sts_nxt[`FAWM_S_WDT] = 1'b0; // R19
    end
    if (!run) begin
      sts_nxt = `FAWM_RST_STS; // R10
    end
    pg_nxt = (flt.pos_ok | ~flt.pos_en) & (flt.neg_ok | ~flt.neg_en); // R9
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sts_r <= `FAWM_RST_STS;
      pg_r  <= 4'h0;
    end else begin
      sts_r <= sts_nxt;
      pg_r  <= pg_nxt;
    end
  end

  // ========================================================
  // Alarm pin, actions and read data
  logic       alarm_r, alarm_nxt, latch_open;
  logic [6:0] live;
  logic [3:0] off_r, off_nxt;
  logic       capp_r, capp_nxt, cstep_r, cstep_nxt;
  logic [5:0] cval_r, cval_nxt;
  logic [1:0] asel, asel_r;
  logic [15:0] rd_r, rd_nxt;
  logic       ot_hit, out_hit, cw_hit;
  assign latch_open = (|flt.boost) && ioc_act != `FAWM_ACT_OFF; // R7 R8
  assign live = {|flt.rail, q_short, sts_r[`FAWM_S_CRC], sts_r[`FAWM_S_WDT],
                 flt.ot, q_comp, q_open | (sts_r[`FAWM_S_OPEN] & latch_open)}; // R7 R18
  assign ot_hit  = flt.ot && ot_act != 2'h0;
  assign out_hit = (q_open || q_comp || q_short) && out_act != 2'h0;
  assign cw_hit  = (sts_set[`FAWM_S_CRC] || wd_to) && cw_act != 2'h0;

  always_comb begin
    alarm_nxt = run && (|(live & ~msk_r)); // R12 R22
    asel = ot_hit ? ot_act : out_hit ? out_act : cw_hit ? cw_act : 2'h0; // R13
    capp_nxt  = run && (capp_r || asel == `FAWM_ACT_CODE); // R14
    cstep_nxt = run && asel == `FAWM_ACT_CODE && !capp_r; // R15
    cval_nxt  = cstep_nxt ? code_r : cval_r;
    if (!run) begin
      cval_nxt = `FAWM_RST_CODE;
    end
    off_nxt = run ? (off_r | (qual[3:0] & {4{ioc_act == `FAWM_ACT_OFF}})) : 4'h0; // R8 R2
    case (req.addr)
      `FAWM_A_REF:  rd_nxt = {14'h0000, ref_r};
      `FAWM_A_WDC:  rd_nxt = {12'h000, wdc_r};
      `FAWM_A_STS:  rd_nxt = {4'h0, pg_r, sts_r};
      `FAWM_A_MSK:  rd_nxt = {9'h000, msk_r};
      `FAWM_A_ACT:  rd_nxt = {8'h00, act_r};
      `FAWM_A_CODE: rd_nxt = {10'h000, code_r};
      default:      rd_nxt = 16'h0000;
    endcase
    if (!req.rd) begin
      rd_nxt = rd_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      alarm_r <= 1'b0;
      asel_r  <= 2'h0;
      capp_r  <= 1'b0;
      cstep_r <= 1'b0;
      cval_r  <= `FAWM_RST_CODE;
      off_r   <= 4'h0;
      rd_r    <= 16'h0000;
    end else begin
      alarm_r <= alarm_nxt;
      asel_r  <= asel;
      capp_r  <= capp_nxt;
      cstep_r <= cstep_nxt;
      cval_r  <= cval_nxt;
      off_r   <= off_nxt;
      rd_r    <= rd_nxt;
    end
  end

  assign alarm_out   = 1'b0;
  assign alarm_oe_n  = ~alarm_r;
  assign ref_en      = ref_r[`FAWM_REF_EN]; // R1
  assign vout_hiz    = ref_r[`FAWM_REF_POC]; // R3
  assign chan_off    = off_r;
  assign code_apply  = capp_r;
  assign code_step   = cstep_r;
  assign code_value  = cval_r;
  assign act_applied = asel_r;
  assign rdata       = rd_r;

  // ========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_ref_off; !run |=> !ref_en; endproperty
  a_ref_off: assert property (p_ref_off) else $error("reference on during reset"); // R1
  property p_rst_clear; !run |=> sts_r == 8'h00 && chan_off == 4'h0 && !code_apply; endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("state not cleared in reset"); // R2
  property p_poc;
    wr_ok && req.addr == `FAWM_A_REF |=> vout_hiz == $past(req.wdata[1]);
  endproperty
  a_poc: assert property (p_poc) else $error("output-off select not applied"); // R3
  property p_open;
    run && flt.open[0] && pc_r[0] == FLT_LIM - 16'h0001 ##1 run |=> sts_r[`FAWM_S_OPEN];
  endproperty
  a_open: assert property (p_open) else $error("open fault not flagged after filter"); // R4
  property p_comp_sat;
    run && wdc_r[`FAWM_WD_SAT] && flt.sat == 4'h0 |=> pc_r[4] == 16'h0000;
  endproperty
  a_comp_sat: assert property (p_comp_sat) else $error("compliance counted unsaturated"); // R5
  property p_latch;
    run && sts_r[`FAWM_S_OPEN] && latch_open && !msk_r[0] |=> alarm_r;
  endproperty
  a_latch: assert property (p_latch) else $error("latched open alarm released"); // R7
  property p_ioc; run && qual[0] && ioc_act == `FAWM_ACT_OFF |=> chan_off[0]; endproperty
  a_ioc: assert property (p_ioc) else $error("channel not disabled on open"); // R8
  property p_pg; flt.pos_en[1] && !flt.pos_ok[1] |=> !pg_r[1]; endproperty
  a_pg: assert property (p_pg) else $error("supply ok with low rail"); // R9
  property p_srst; wr_ok && req.addr == `FAWM_A_SWRST |=> !run [*8]; endproperty
  a_srst: assert property (p_srst) else $error("software reset too short"); // R10
  property p_reassert; run && flt.ot ##1 run |-> sts_r[`FAWM_S_OT]; endproperty
  a_reassert: assert property (p_reassert) else $error("status not reasserted"); // R11
  property p_mask; msk_r == 7'h7F |=> !alarm_r; endproperty
  a_mask: assert property (p_mask) else $error("masked fault drove alarm"); // R12
  property p_prio; ot_hit |=> act_applied == $past(ot_act); endproperty
  a_prio: assert property (p_prio) else $error("action priority wrong"); // R13
  property p_code_hold; capp_r && run |=> capp_r; endproperty
  a_code_hold: assert property (p_code_hold) else $error("fault code released"); // R14
  property p_step; $rose(code_apply) |-> code_step && code_value == $past(code_r); endproperty
  a_step: assert property (p_step) else $error("code not stepped in"); // R15
  property p_wd_off; !wd_en |=> wd_r == 24'h000000; endproperty
  a_wd_off: assert property (p_wd_off) else $error("watchdog ran disabled"); // R16
  property p_wd_to; run && wd_to ##1 run && !msk_r[3] |-> sts_r[`FAWM_S_WDT] ##1 alarm_r; endproperty
  a_wd_to: assert property (p_wd_to) else $error("timeout not flagged"); // R18
  property p_wd_clr; !wd_en |=> !sts_r[`FAWM_S_WDT]; endproperty
  a_wd_clr: assert property (p_wd_clr) else $error("timeout flag kept when disabled"); // R19
  property p_clamp_learned_flag; run && flt.clamp_done ##1 run |-> sts_r[`FAWM_S_CLAMP_LEARNED_FLAG]; endproperty
  a_clamp_learned_flag: assert property (p_clamp_learned_flag) else $error("clamp learned not flagged"); // R21
  property p_alarm; run && flt.ot && !msk_r[2] |=> alarm_r; endproperty
  a_alarm: assert property (p_alarm) else $error("unmasked fault without alarm"); // R22 R6

  c_alarm: cover property ($rose(alarm_r));
  c_code: cover property ($rose(code_apply));
  c_wd: cover property (wd_to);
  c_off: cover property ($rose(chan_off[0]));
endmodule
`default_nettype wire

// ### verilog/fawm_regs.svh
// Register offsets, field positions, reset values and timing of the fault monitor
`ifndef FAWM_REGS_SVH
`define FAWM_REGS_SVH
// ==========================================================
// Register offsets
`define FAWM_A_SWRST 8'h01
`define FAWM_A_REF   8'h02
`define FAWM_A_WDC   8'h03
`define FAWM_A_STS   8'h0B
`define FAWM_A_MSK   8'h0C
`define FAWM_A_ACT   8'h0D
`define FAWM_A_CODE  8'h0E
`define FAWM_A_WDR   8'h10
// ==========================================================
// Field positions
`define FAWM_REF_EN  0
`define FAWM_REF_POC 1
`define FAWM_WD_EN   0
`define FAWM_WD_PER  1
`define FAWM_WD_SAT  3
`define FAWM_S_OPEN  0
`define FAWM_S_COMP  1
`define FAWM_S_OT    2
`define FAWM_S_WDT   3
`define FAWM_S_CRC   4
`define FAWM_S_SHORT 5
`define FAWM_S_RAIL  6
`define FAWM_S_CLAMP_LEARNED_FLAG  7
`define FAWM_ACT_OT  0
`define FAWM_ACT_OUT 2
`define FAWM_ACT_CW  4
`define FAWM_ACT_IOC 6
`define FAWM_ACT_CODE 2'h1
`define FAWM_ACT_OFF  2'h2
// ==========================================================
// Reset values
`define FAWM_RST_REF  2'h0
`define FAWM_RST_WDC  4'h0
`define FAWM_RST_STS  8'h00
`define FAWM_RST_MSK  7'h00
`define FAWM_RST_ACT  8'h00
`define FAWM_RST_CODE 6'h00
// ==========================================================
// Timing
`define FAWM_CLK_MHZ 25
`define FAWM_FLT_US  500
`define FAWM_SRST_US 8
`define FAWM_SRST_CYC (`FAWM_SRST_US * `FAWM_CLK_MHZ)
`define FAWM_WD_US0  1000
`define FAWM_WD_US1  2000
`define FAWM_WD_US2  4000
`define FAWM_WD_US3  8000
`endif

// ### verilog/fawm_pkg.sv
// Types shared by the fault monitor
`default_nettype none
package fawm_pkg;
  // ========================================================
  // Register access from the serial frame decoder
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } fawm_req_t;
  // ========================================================
  // Analog fault sensing, one bit per channel except ot, crc_err and clamp_done
  typedef struct packed {
    logic [3:0] open;
    logic [3:0] comp;
    logic [3:0] shrt;
    logic [3:0] rail;
    logic [3:0] sat;
    logic [3:0] boost;
    logic [3:0] pos_en;
    logic [3:0] neg_en;
    logic [3:0] pos_ok;
    logic [3:0] neg_ok;
    logic       ot;
    logic       crc_err;
    logic       clamp_done;
  } fawm_flt_t;
  typedef enum logic [1:0] {
    FAWM_RUN = 2'b01,
    FAWM_CLR = 2'b10
  } fawm_seq_t;
endpackage
`default_nettype wire

// ### tb/fawm_host_model.sv
// Host processor model issuing register requests to the fault monitor
`default_nettype none
module fawm_host_model
  import fawm_pkg::*;
(
  // Clock
  input  wire logic        sys_clk,
  // Register port
  output var  fawm_req_t   req,
  input  wire logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================================
  // Bus cycles
  initial req = '0;
  // Idle address and data are inverted so a stale value is never reused
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge sys_clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // Status is always read back in full, never inferred from the pin
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge sys_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge sys_clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hFFFF};
    d = rdata;
  endtask
endmodule
`default_nettype wire

// ### tb/fault_alarm_watchdog_monitor_tb.sv
// Self-checking bench of the fault monitor
`include "fawm_regs.svh"
`default_nettype none
module fault_alarm_watchdog_monitor_tb;
  import fawm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk;
  logic        rst;
  fawm_req_t   req;
  logic [15:0] rdata;
  fawm_flt_t   flt;
  logic        alarm_out;
  logic        alarm_oe_n;
  logic        ref_en;
  logic        vout_hiz;
  logic [3:0]  chan_off;
  logic        code_apply;
  logic        code_step;
  logic [5:0]  code_value;
  logic [1:0]  act_applied;
  logic [15:0] v;
  int          num_errors;
  int          n_checks;
  int          cycles;
  int          steps;
  logic [7:0]  ra [7] = '{`FAWM_A_SWRST, `FAWM_A_REF, `FAWM_A_WDC, `FAWM_A_MSK,
                          `FAWM_A_ACT, `FAWM_A_CODE, 8'h05};
  // ========================================================
  // Design and host
  // Short filter and watchdog counts keep the run brief
  fawm_monitor #(.FLT_CYC(20), .WD_CYC0(30), .WD_CYC1(40), .WD_CYC2(50), .WD_CYC3(60)) DUT (
    .sys_clk(sys_clk), .rst(rst), .req(req), .rdata(rdata), .flt(flt),
    .alarm_out(alarm_out), .alarm_oe_n(alarm_oe_n), .ref_en(ref_en), .vout_hiz(vout_hiz),
    .chan_off(chan_off), .code_apply(code_apply), .code_step(code_step),
    .code_value(code_value), .act_applied(act_applied));
  fawm_host_model host (.sys_clk(sys_clk), .req(req), .rdata(rdata));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (code_step === 1'b1) begin
      steps++;
    end
    if (cycles == 3000) begin
      num_errors++;
      stop_test();
    end
  end
  // ========================================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e, input string nm);
    host.rd(a, v);
    chk(nm, e, v & m);
  endtask
  task automatic pin(input logic e);
    chk("alarm_oe_n", {15'h0000, e}, {15'h0000, alarm_oe_n});
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ========================================================
  // Scenarios
  task automatic t_reset();
    chk("ref_en", 16'h0000, {15'h0000, ref_en});
    chk("vout_hiz", 16'h0000, {15'h0000, vout_hiz});
    chk("chan_off", 16'h0000, {12'h000, chan_off});
    pin(1'b1);
    foreach (ra[i]) rc(ra[i], 16'hFFFF, 16'h0000, "reset_read");
    rc(`FAWM_A_STS, 16'hF0FF, 16'h0000, "status");
    host.wr(`FAWM_A_REF, 16'h0003);
    chk("ref_en", 16'h0001, {15'h0000, ref_en});
    chk("vout_hiz", 16'h0001, {15'h0000, vout_hiz});
    $display("test reset done");
  endtask
  task automatic t_ot();
    flt.ot = 1'b1;
    cyc(2);
    pin(1'b0);
    chk("alarm_out", 16'h0000, {15'h0000, alarm_out});
    flt.ot = 1'b0;
    cyc(2);
    pin(1'b1);
    rc(`FAWM_A_STS, 16'h00FF, 16'h0004, "status");
    host.wr(`FAWM_A_STS, 16'h0004);
    rc(`FAWM_A_STS, 16'h00FF, 16'h0000, "status");
    flt.ot = 1'b1;
    host.wr(`FAWM_A_STS, 16'h0004);
    rc(`FAWM_A_STS, 16'h00FF, 16'h0004, "status");
    host.wr(`FAWM_A_MSK, 16'h0004);
    cyc(2);
    pin(1'b1);
    host.wr(`FAWM_A_MSK, 16'h007F);
    cyc(2);
    pin(1'b1);
    host.wr(`FAWM_A_MSK, 16'h0000);
    cyc(2);
    pin(1'b0);
    flt.ot = 1'b0;
    flt.crc_err = 1'b1;
    cyc(1);
    flt.crc_err = 1'b0;
    cyc(3);
    pin(1'b0);
    host.wr(`FAWM_A_STS, 16'h0010);
    flt.rail[2] = 1'b1;
    cyc(2);
    pin(1'b0);
    flt.rail[2] = 1'b0;
    host.wr(`FAWM_A_SWRST, 16'h0000);
    cyc(202);
    rc(`FAWM_A_STS, 16'h00FF, 16'h0000, "status");
    chk("ref_en", 16'h0000, {15'h0000, ref_en});
    $display("test status done");
  endtask
  task automatic t_open();
    flt.open[0] = 1'b1;
    flt.boost[0] = 1'b1;
    cyc(10);
    pin(1'b1);
    cyc(15);
    pin(1'b0);
    flt.open[0] = 1'b0;
    cyc(3);
    pin(1'b0);
    host.wr(`FAWM_A_STS, 16'h0001);
    cyc(2);
    pin(1'b1);
    host.wr(`FAWM_A_ACT, 16'h0080);
    flt.open[0] = 1'b1;
    cyc(25);
    chk("chan_off", 16'h0001, {12'h000, chan_off});
    flt.open[0] = 1'b0;
    cyc(3);
    pin(1'b1);
    flt.boost[0] = 1'b0;
    $display("test open done");
  endtask
  task automatic t_wd();
    host.wr(`FAWM_A_WDC, 16'h0001);
    repeat (3) begin
      cyc(15);
      host.wr(`FAWM_A_WDR, 16'h0000);
    end
    pin(1'b1);
    cyc(40);
    pin(1'b0);
    rc(`FAWM_A_STS, 16'h0008, 16'h0008, "wd_flag");
    host.wr(`FAWM_A_WDC, 16'h0000);
    rc(`FAWM_A_STS, 16'h0008, 16'h0000, "wd_flag");
    host.wr(`FAWM_A_WDC, 16'h0007);
    cyc(40);
    pin(1'b1);
    cyc(30);
    pin(1'b0);
    host.wr(`FAWM_A_WDC, 16'h0000);
    $display("test watchdog done");
  endtask
  task automatic t_code();
    host.wr(`FAWM_A_CODE, 16'h002A);
    host.wr(`FAWM_A_ACT, 16'h0009);
    flt.ot = 1'b1;
    flt.shrt[1] = 1'b1;
    cyc(25);
    chk("act_applied", 16'h0001, {14'h0000, act_applied});
    chk("code_value", 16'h002A, {10'h000, code_value});
    flt.ot = 1'b0;
    flt.shrt[1] = 1'b0;
    cyc(3);
    chk("code_apply", 16'h0001, {15'h0000, code_apply});
    chk("code_step", 16'h0001, steps[15:0]);
    $display("test code done");
  endtask
  task automatic t_pg();
    flt.pos_en[1] = 1'b1;
    cyc(2);
    rc(`FAWM_A_STS, 16'h0200, 16'h0000, "supply_ok");
    flt.pos_ok[1] = 1'b1;
    cyc(2);
    rc(`FAWM_A_STS, 16'h0200, 16'h0200, "supply_ok");
    flt.neg_en[1] = 1'b1;
    cyc(2);
    rc(`FAWM_A_STS, 16'h0200, 16'h0000, "supply_ok");
    host.wr(`FAWM_A_STS, 16'h00FF);
    flt.clamp_done = 1'b1;
    cyc(1);
    flt.clamp_done = 1'b0;
    cyc(2);
    rc(`FAWM_A_STS, 16'h0080, 16'h0080, "clamp_flag");
    pin(1'b1);
    // Compliance only counts once the converter reports saturation
    host.wr(`FAWM_A_WDC, 16'h0008);
    flt.comp[2] = 1'b1;
    cyc(25);
    rc(`FAWM_A_STS, 16'h0002, 16'h0000, "comp_flag");
    flt.sat[2] = 1'b1;
    cyc(25);
    pin(1'b0);
    rc(`FAWM_A_STS, 16'h0002, 16'h0002, "comp_flag");
    flt.comp[2] = 1'b0;
    flt.sat[2] = 1'b0;
    $display("test supply done");
  endtask
  // ========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    flt = '0;
    num_errors = 0;
    n_checks = 0;
    cycles = 0;
    steps = 0;
    cyc(20);
    rst = 1'b0;
    cyc(202);
    t_reset();
    t_ot();
    t_open();
    t_wd();
    t_code();
    t_pg();
    stop_test();
  end
endmodule
`default_nettype wire
